// File: logic/sdms_pkg.sv
/*
 * constants, types and decode helpers for the special drive mode selector.
 * assumes one 125 MHz clock, a 12-bit analog sample spanning 0..10 V,
 * and the remaining drive logic consuming the selected mode and setpoints.
 */
package sdms_pkg;

   // ************************************************************
   // register map, byte addresses of 32-bit words
   // ************************************************************
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_OPMODE = 8'h04;
   localparam logic [7:0] REG_CTLWORD = 8'h08;
   localparam logic [7:0] REG_TVEL = 8'h0C;
   localparam logic [7:0] REG_SCALE_NUM = 8'h10;
   localparam logic [7:0] REG_SCALE_DEN = 8'h14;
   localparam logic [7:0] REG_STATUS = 8'h18;
   localparam logic [7:0] REG_AS_RES = 8'h1C;
   localparam logic [7:0] REG_AS_IND = 8'h20;
   localparam int CTRL_SPECIAL_BIT = 0;
   localparam int CTRL_RESTART_BIT = 1;
   localparam logic [15:0] SCALE_RST = 16'h0001;

   // ************************************************************
   // object values
   // ************************************************************
   localparam logic [7:0] OPM_VEL = 8'h02;
   localparam logic [7:0] OPM_CLKDIR = 8'h80; // arbitrary internal code
   localparam logic [15:0] CW_ENABLE = 16'h000F;
   localparam logic [15:0] CW_STOP = 16'h0006;
   localparam logic [7:0] STORE_DRIVE = 8'h05;
   localparam logic [7:0] STORE_TUNING = 8'h06;
   localparam logic [3:0] SW_SHIP = 4'h1;
   localparam logic [1:0] RESTART_WAIT = 2'h3;

   // ************************************************************
   // analog scaling
   // ************************************************************
   localparam int ADC_STEPS = 4096;
   localparam int ADC_FS_MV = 10000;
   localparam int DEAD_MV = 20;
   localparam logic [11:0] DEAD_CNT = 12'((DEAD_MV * ADC_STEPS) / ADC_FS_MV);
   localparam logic [11:0] ADC_MAX = 12'hFFF;
   localparam logic [11:0] ADC_MID = 12'h800;
   localparam logic [31:0] RPM_HI = 32'h0000_03E8;
   localparam logic [31:0] RPM_LO = 32'h0000_0064;
   localparam logic signed [15:0] RPM_TEST = 16'sh001E;

   typedef enum logic [1:0] {SDMS_STEP, SDMS_TEST, SDMS_ANALOG, SDMS_JOY} sdms_mode_t;
   typedef enum logic {SDMS_PWR_OFF, SDMS_PWR_ON} sdms_pwr_t;
   typedef enum logic [1:0] {SDMS_ST_IDLE, SDMS_ST_TUNE} sdms_store_t;

   // switch code bits 2:1 pick the family, bit 3 the loop
   function automatic sdms_mode_t code_mode(input logic [3:0] code);
      case (code[2:1])
         2'h0: code_mode = SDMS_STEP;
         2'h1: code_mode = SDMS_TEST;
         2'h2: code_mode = SDMS_ANALOG;
         default: code_mode = SDMS_JOY;
      endcase
   endfunction

endpackage

// File: logic/sdms_scale.sv
/*
 * analog voltage to signed speed in rpm, one cycle of latency.
 * assumes a synchronised 12-bit sample and a stable mode selection.
 */
module sdms_scale (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic srst_i,
   // sample and selection
   input wire logic [11:0] adc_i,
   input wire logic dir_i,
   input wire logic joy_i,
   input wire logic hi_range_i,
   input wire logic [15:0] num_i,
   input wire logic [15:0] den_i,
   // result
   output logic signed [15:0] vel_o
);

   logic signed [12:0] diff;
   logic [11:0] mag;
   logic [11:0] span;
   logic [31:0] fs;
   logic [31:0] raw;
   logic [31:0] den;
   logic [31:0] scaled;
   logic [14:0] sat;
   logic neg;
   logic dead;

   // joystick measures from the midpoint, normal from zero
   assign diff = signed'({1'b0, adc_i}) - signed'({1'b0, sdms_pkg::ADC_MID});
   assign mag = joy_i ? (diff < 0 ? 12'(-diff) : 12'(diff)) : adc_i;
   assign span = joy_i ? sdms_pkg::ADC_MID : sdms_pkg::ADC_MAX;
   assign dead = mag <= sdms_pkg::DEAD_CNT;
   // idle direction pin reads low, giving positive clockwise speed
   assign neg = joy_i ? (diff < 0) : dir_i;
   // base range then user factor; zero denominator treated as one
   assign fs = hi_range_i ? sdms_pkg::RPM_HI : sdms_pkg::RPM_LO;
   assign raw = (32'(mag) * fs) / 32'(span);
   assign den = (den_i == 16'h0000) ? 32'h0000_0001 : 32'(den_i);
   assign scaled = (raw * 32'(num_i)) / den;
   assign sat = (scaled > 32'h0000_7FFF) ? 15'h7FFF : scaled[14:0];

   // registered result keeps the divider path off the outputs
   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i || dead)
         vel_o <= 16'sh0000;
      else
         vel_o <= neg ? -signed'({1'b0, sat}) : signed'({1'b0, sat});
   end

endmodule

// File: logic/sdms_sync.sv
/*
 * two-stage synchroniser for a bundle of pin levels.
 * assumes each bit is a slow level; no bus coherence is promised.
 */
module sdms_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic srst_i,
   // pins
   input wire logic [W-1:0] pin_i,
   output logic [W-1:0] sync_o
);

   logic [W-1:0] meta_reg;

   // first stage feeds only the second
   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i)
      begin
         meta_reg <= '0;
         sync_o <= '0;
      end
      else
      begin
         meta_reg <= pin_i;
         sync_o <= meta_reg;
      end
   end

endmodule

// File: logic/sdms_top.sv
/*
 * special drive mode selector: restart-time capture of switches and
 * configuration, power state from enable pin or control word, setpoint
 * generation and auto setup parameter storage requests.
 * assumes motor loops, power stage and non-volatile storage sit outside.
 */
// The implementer's own choices: strobed register access and the register addresses.
module sdms_top (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic srst_i,
   // register port
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   // pins
   input wire logic enable_pin_i,
   input wire logic clock_pin_i,
   input wire logic dir_pin_i,
   input wire logic [11:0] adc_i,
   input wire logic [3:0] low_digit_rotary_switch_i,
   input wire logic [3:0] high_digit_rotary_switch_i,
   input wire logic cfg_special_i,
   // auto setup results
   input wire logic as_done_i,
   input wire logic [15:0] as_res_i,
   input wire logic [15:0] as_ind_i,
   // drive control
   output logic [7:0] op_mode_o,
   output logic drive_en_o,
   output logic closed_loop_o,
   output logic signed [15:0] target_vel_o,
   output logic step_o,
   output logic step_dir_o,
   output logic [7:0] node_id_o,
   // storage requests
   output logic store_req_o,
   output logic [7:0] store_cat_o
);

   // ************************************************************
   // pin synchronisation
   // ************************************************************
   logic [2:0] pins_s;
   logic [7:0] sw_s;
   logic [11:0] adc_s;
   logic en_s;

   sdms_sync #(.W(23)) u_sync (
      .sys_clk_i(sys_clk_i),
      .srst_i(srst_i),
      .pin_i({enable_pin_i, clock_pin_i, dir_pin_i, high_digit_rotary_switch_i,
         low_digit_rotary_switch_i, adc_i}),
      .sync_o({pins_s, sw_s, adc_s})
   );
   assign en_s = pins_s[2];

   // ************************************************************
   // registers
   // ************************************************************
   logic ctl_special_reg, coord_bad_reg, special_reg, stored_reg;
   logic [7:0] opm_reg;
   logic [15:0] cw_reg, num_reg, den_reg, as_res_reg, as_ind_reg;
   logic signed [15:0] tvel_reg;
   logic [3:0] code_reg;
   logic [1:0] pend_reg;
   sdms_pkg::sdms_pwr_t pwr_reg, pwr_next;
   sdms_pkg::sdms_store_t st_reg;

   logic wr_ctrl, wr_opm, wr_cw, wr_tv, wr_num, wr_den;
   logic restart_req, capture, mode_analog;
   sdms_pkg::sdms_mode_t mode;
   logic signed [15:0] ana_vel, tgt_next;
   logic [7:0] opm_next;
   logic [31:0] status, rd_mux;

   // write decode
   assign wr_ctrl = wr_i && (addr_i == sdms_pkg::REG_CTRL);
   assign wr_opm = wr_i && (addr_i == sdms_pkg::REG_OPMODE);
   assign wr_cw = wr_i && (addr_i == sdms_pkg::REG_CTLWORD);
   assign wr_tv = wr_i && (addr_i == sdms_pkg::REG_TVEL);
   assign wr_num = wr_i && (addr_i == sdms_pkg::REG_SCALE_NUM);
   assign wr_den = wr_i && (addr_i == sdms_pkg::REG_SCALE_DEN);
   assign restart_req = wr_ctrl && wdata_i[sdms_pkg::CTRL_RESTART_BIT];

   // software registers; a soft restart keeps all but the CTRL special bit, which its own write reloads; srst clears them and sets both scale factors to one
   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i)
      begin
         ctl_special_reg <= 1'b0;
         opm_reg <= 8'h00;
         cw_reg <= 16'h0000;
         tvel_reg <= 16'sh0000;
         num_reg <= sdms_pkg::SCALE_RST;
         den_reg <= sdms_pkg::SCALE_RST;
      end
      else
      begin
         if (wr_ctrl)
            ctl_special_reg <= wdata_i[sdms_pkg::CTRL_SPECIAL_BIT];
         if (wr_opm)
            opm_reg <= wdata_i[7:0];
         if (wr_cw)
            cw_reg <= wdata_i[15:0];
         if (wr_tv)
            tvel_reg <= signed'(wdata_i[15:0]);
         if (wr_num)
            num_reg <= wdata_i[15:0];
         if (wr_den)
            den_reg <= wdata_i[15:0];
      end
   end

   // ************************************************************
   // restart-time capture
   // ************************************************************
   // wait for the synchroniser to fill before sampling the switches
   assign capture = (pend_reg == 2'h1);

   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i)
      begin
         pend_reg <= sdms_pkg::RESTART_WAIT;
         code_reg <= sdms_pkg::SW_SHIP;
         special_reg <= 1'b0;
         node_id_o <= 8'h00;
      end
      else
      begin
         if (restart_req)
            pend_reg <= sdms_pkg::RESTART_WAIT;
         else if (pend_reg != 2'h0)
            pend_reg <= pend_reg - 2'h1;
         // values frozen between restarts, never taken while running
         if (capture)
         begin
            code_reg <= sw_s[3:0];
            special_reg <= cfg_special_i | ctl_special_reg;
            node_id_o <= sw_s;
         end
      end
   end

   // ************************************************************
   // mode decode and power state
   // ************************************************************
   assign mode = sdms_pkg::code_mode(code_reg);
   assign mode_analog = (mode == sdms_pkg::SDMS_ANALOG) || (mode == sdms_pkg::SDMS_JOY);

   // enable pin owns the state in special modes; control word otherwise
   assign pwr_next = (coord_bad_reg || capture) ? sdms_pkg::SDMS_PWR_OFF :
      special_reg ? (en_s ? sdms_pkg::SDMS_PWR_ON : sdms_pkg::SDMS_PWR_OFF) :
      (wr_cw && wdata_i[15:0] == sdms_pkg::CW_ENABLE) ? sdms_pkg::SDMS_PWR_ON :
      (wr_cw && wdata_i[15:0] == sdms_pkg::CW_STOP) ? sdms_pkg::SDMS_PWR_OFF : pwr_reg;

   sdms_scale u_scale (
      .sys_clk_i(sys_clk_i),
      .srst_i(srst_i),
      .adc_i(adc_s),
      .dir_i(pins_s[0]),
      .joy_i(mode == sdms_pkg::SDMS_JOY),
      .hi_range_i(!code_reg[0]),
      .num_i(num_reg),
      .den_i(den_reg),
      .vel_o(ana_vel)
   );

   // setpoint and internal operating mode; software values pass when special is off
   assign tgt_next = !special_reg ? tvel_reg :
      (mode == sdms_pkg::SDMS_STEP) ? 16'sh0000 :
      (mode == sdms_pkg::SDMS_TEST) ? (code_reg[0] ? -sdms_pkg::RPM_TEST : sdms_pkg::RPM_TEST) :
      ana_vel;
   assign opm_next = !special_reg ? opm_reg :
      (mode == sdms_pkg::SDMS_STEP) ? sdms_pkg::OPM_CLKDIR : sdms_pkg::OPM_VEL;

   // drive outputs; nothing moves while disabled
   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i)
      begin
         pwr_reg <= sdms_pkg::SDMS_PWR_OFF;
         op_mode_o <= 8'h00;
         drive_en_o <= 1'b0;
         closed_loop_o <= 1'b0;
         target_vel_o <= 16'sh0000;
         step_o <= 1'b0;
         step_dir_o <= 1'b0;
      end
      else
      begin
         pwr_reg <= pwr_next;
         op_mode_o <= opm_next;
         drive_en_o <= (pwr_reg == sdms_pkg::SDMS_PWR_ON);
         closed_loop_o <= code_reg[3];
         target_vel_o <= (pwr_reg == sdms_pkg::SDMS_PWR_ON) ? tgt_next : 16'sh0000;
         step_o <= special_reg && (mode == sdms_pkg::SDMS_STEP) &&
            (pwr_reg == sdms_pkg::SDMS_PWR_ON) && pins_s[1];
         step_dir_o <= pins_s[0];
      end
   end

   // ************************************************************
   // auto setup storage
   // ************************************************************
   // results copied, then drive and tuning categories stored in turn
   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i)
      begin
         st_reg <= sdms_pkg::SDMS_ST_IDLE;
         store_req_o <= 1'b0;
         store_cat_o <= 8'h00;
         as_res_reg <= 16'h0000;
         as_ind_reg <= 16'h0000;
         stored_reg <= 1'b0;
         coord_bad_reg <= 1'b0;
      end
      else
      begin
         store_req_o <= 1'b0;
         case (st_reg)
            sdms_pkg::SDMS_ST_IDLE:
               if (as_done_i)
               begin
                  as_res_reg <= as_res_i;
                  as_ind_reg <= as_ind_i;
                  store_req_o <= 1'b1;
                  store_cat_o <= sdms_pkg::STORE_DRIVE;
                  st_reg <= sdms_pkg::SDMS_ST_TUNE;
               end
            sdms_pkg::SDMS_ST_TUNE:
            begin
               store_req_o <= 1'b1;
               store_cat_o <= sdms_pkg::STORE_TUNING;
               stored_reg <= 1'b1;
               st_reg <= sdms_pkg::SDMS_ST_IDLE;
            end
            default:
               st_reg <= sdms_pkg::SDMS_ST_IDLE;
         endcase
         // coordinates stay invalid until the next restart; set wins
         if (as_done_i)
            coord_bad_reg <= 1'b1;
         else if (capture)
            coord_bad_reg <= 1'b0;
      end
   end

   // ************************************************************
   // read port
   // ************************************************************
   assign status = {16'h0000, 3'h0, stored_reg, coord_bad_reg, special_reg,
      pwr_reg == sdms_pkg::SDMS_PWR_ON, code_reg[3], node_id_o};
   assign rd_mux = (addr_i == sdms_pkg::REG_CTRL) ? {31'h0, ctl_special_reg} :
      (addr_i == sdms_pkg::REG_OPMODE) ? {24'h0, opm_reg} :
      (addr_i == sdms_pkg::REG_CTLWORD) ? {16'h0, cw_reg} :
      (addr_i == sdms_pkg::REG_TVEL) ? {16'h0, target_vel_o} :
      (addr_i == sdms_pkg::REG_SCALE_NUM) ? {16'h0, num_reg} :
      (addr_i == sdms_pkg::REG_SCALE_DEN) ? {16'h0, den_reg} :
      (addr_i == sdms_pkg::REG_STATUS) ? status :
      (addr_i == sdms_pkg::REG_AS_RES) ? {16'h0, as_res_reg} :
      (addr_i == sdms_pkg::REG_AS_IND) ? {16'h0, as_ind_reg} : 32'h0000_0000;

   // data valid only in the cycle after the strobe
   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i || !rd_i)
         rdata_o <= 32'h0000_0000;
      else
         rdata_o <= rd_mux;
   end

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (srst_i);

   property p_store_seq;
      as_done_i && st_reg == sdms_pkg::SDMS_ST_IDLE |=> store_req_o && store_cat_o == 8'h05
         ##1 store_req_o && store_cat_o == 8'h06 ##1 !store_req_o;
   endproperty
   a_store_seq: assert property (p_store_seq) else $error("storage sequence wrong");
   property p_special_gate;
      !special_reg |=> op_mode_o == $past(opm_reg);
   endproperty
   a_special_gate: assert property (p_special_gate) else $error("op mode overridden");
   property p_pin_off;
      special_reg && !en_s |=> pwr_reg == sdms_pkg::SDMS_PWR_OFF ##1 !drive_en_o;
   endproperty
   a_pin_off: assert property (p_pin_off) else $error("enable pin low ignored");
   property p_pin_on;
      special_reg && en_s && !coord_bad_reg && !capture |=> pwr_reg == sdms_pkg::SDMS_PWR_ON;
   endproperty
   a_pin_on: assert property (p_pin_on) else $error("enable pin high ignored");
   property p_frozen;
      pend_reg == 2'h0 && !restart_req |=> $stable(code_reg) && $stable(special_reg);
   endproperty
   a_frozen: assert property (p_frozen) else $error("mode changed while running");
   property p_step_mode;
      special_reg && mode == sdms_pkg::SDMS_STEP |=> op_mode_o == 8'h80;
   endproperty
   a_step_mode: assert property (p_step_mode) else $error("step mode not selected");
   property p_analog_mode;
      special_reg && mode_analog |=> op_mode_o == 8'h02;
   endproperty
   a_analog_mode: assert property (p_analog_mode) else $error("velocity mode not selected");
   property p_dead;
      (special_reg && mode == sdms_pkg::SDMS_ANALOG && adc_s <= 12'h008) ##1
         pwr_reg == sdms_pkg::SDMS_PWR_ON |=> target_vel_o == 16'sh0000;
   endproperty
   a_dead: assert property (p_dead) else $error("motion inside dead zone");
   property p_test;
      special_reg && mode == sdms_pkg::SDMS_TEST && pwr_reg == sdms_pkg::SDMS_PWR_ON
         |=> target_vel_o == (code_reg[0] ? -16'sd30 : 16'sd30);
   endproperty
   a_test: assert property (p_test) else $error("test run speed wrong");
   property p_node;
      capture |=> node_id_o == {$past(sw_s[7:4]), $past(sw_s[3:0])};
   endproperty
   a_node: assert property (p_node) else $error("combined switch value wrong");
   property p_idle;
      pwr_reg == sdms_pkg::SDMS_PWR_OFF |=> target_vel_o == 16'sh0000 && !drive_en_o && !step_o;
   endproperty
   a_idle: assert property (p_idle) else $error("motion while disabled");
   c_store: cover property (as_done_i ##2 store_cat_o == 8'h06);
   c_test_run: cover property (special_reg && mode == sdms_pkg::SDMS_TEST && drive_en_o);
   c_analog: cover property (special_reg && mode_analog && target_vel_o != 16'sh0000);
   c_cw_stop: cover property (!special_reg && drive_en_o ##1 wr_cw ##2 !drive_en_o);

endmodule

// File: testbench/sdms_far.sv
/*
 * far-side model: fieldbus register master and pin sources for the selector.
 * assumes the bench calls its tasks; every task drive lands just after a rising edge.
 */
module sdms_far (
   // clock
   input wire logic sys_clk_i,
   // register port
   output logic [7:0] addr_o,
   output logic [31:0] wdata_o,
   output logic wr_o,
   output logic rd_o,
   input wire logic [31:0] rdata_i,
   // pins
   output logic en_o,
   output logic clk_o,
   output logic dir_o,
   output logic [11:0] adc_o,
   output logic [7:0] sw_o,
   output logic cfg_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // idle levels at time zero, low digit at its shipped setting
   initial
   begin
      {addr_o, wdata_o, wr_o, rd_o} = '0;
      {en_o, clk_o, dir_o, adc_o, cfg_o} = '0;
      sw_o = 8'h01;
   end
   // one-cycle write; data turned over after so a stale word never looks held
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= 1'b1;
      @(posedge sys_clk_i);
      wr_o <= 1'b0;
      wdata_o <= ~d;
   endtask
   // one-cycle read; answer stands only in the following cycle
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk_i);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge sys_clk_i);
      rd_o <= 1'b0;
      #1;
      d = rdata_i;
   endtask
   // enable pin is digital input 1
   task automatic pins(input logic en, input logic ck, input logic dir, input logic [11:0] adc);
      @(posedge sys_clk_i);
      en_o <= en;
      clk_o <= ck;
      dir_o <= dir;
      adc_o <= adc;
   endtask
   // switches are slow levels; give the synchroniser time to settle
   task automatic set_sw(input logic [7:0] s, input logic c);
      @(posedge sys_clk_i);
      sw_o <= s;
      cfg_o <= c;
      repeat (3) @(posedge sys_clk_i);
   endtask
   task automatic restart(input logic [7:0] s, input logic c);
      set_sw(s, c);
      wr(sdms_pkg::REG_CTRL, 32'h2);
      repeat (6) @(posedge sys_clk_i);
   endtask
   task automatic vel_run(input logic [15:0] v);
      wr(sdms_pkg::REG_OPMODE, 32'h2);
      wr(sdms_pkg::REG_TVEL, {16'h0, v});
      wr(sdms_pkg::REG_CTLWORD, 32'hF);
   endtask
   task automatic vel_stop;
      wr(sdms_pkg::REG_CTLWORD, 32'h6);
   endtask
endmodule

// File: testbench/sdms_top_tb.sv
/*
 * self-checking bench for the special drive mode selector.
 * assumes the far-side model sdms_far and the package constants.
 */
module sdms_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic [7:0] addr, op_mode, node_id, cat, sw;
   logic [31:0] wdata, rdata, d;
   logic wr, rd, en, ck, dir, cfg, drv, cl, step, sdir, req;
   logic as_done = 1'b0;
   logic [11:0] adc;
   logic [15:0] as_res = 16'h1234;
   logic signed [15:0] vel;
   int miscompares = 0;
   int tests_run = 0;
   // 125 MHz
   always #4 sys_clk_i = ~sys_clk_i;
   sdms_top sdms_top_i (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
      .rd_i(rd), .rdata_o(rdata), .enable_pin_i(en), .clock_pin_i(ck), .dir_pin_i(dir), .adc_i(adc),
      .low_digit_rotary_switch_i(sw[3:0]), .high_digit_rotary_switch_i(sw[7:4]), .cfg_special_i(cfg),
      .as_done_i(as_done), .as_res_i(as_res), .as_ind_i(~as_res), .op_mode_o(op_mode), .drive_en_o(drv),
      .closed_loop_o(cl), .target_vel_o(vel), .step_o(step), .step_dir_o(sdir), .node_id_o(node_id),
      .store_req_o(req), .store_cat_o(cat));
   sdms_far sdms_far_i (.sys_clk_i(sys_clk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
      .rdata_i(rdata), .en_o(en), .clk_o(ck), .dir_o(dir), .adc_o(adc), .sw_o(sw), .cfg_o(cfg));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic results;
      $display("compares %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // fieldbus velocity run with special modes off
   task automatic t_vel;
      sdms_far_i.vel_run(16'h00C8);
      repeat (4) @(posedge sys_clk_i);
      sdms_far_i.rd(sdms_pkg::REG_STATUS, d);
      chk(d[11:0], 12'h201);
      chk({drv, vel, op_mode}, {1'b1, 16'h00C8, sdms_pkg::OPM_VEL});
      sdms_far_i.vel_stop();
      repeat (4) @(posedge sys_clk_i);
      chk(drv, 1'b0);
   endtask
   // auto setup stores drive then tuning; enabling refused until restart
   task automatic t_auto;
      @(posedge sys_clk_i);
      as_done <= 1'b1;
      @(posedge sys_clk_i);
      as_done <= 1'b0;
      #1;
      chk({req, cat}, {1'b1, sdms_pkg::STORE_DRIVE});
      @(posedge sys_clk_i);
      #1;
      chk({req, cat}, {1'b1, sdms_pkg::STORE_TUNING});
      @(posedge sys_clk_i);
      #1;
      chk(req, 1'b0);
      sdms_far_i.rd(sdms_pkg::REG_AS_RES, d);
      chk(d, 32'h1234);
      sdms_far_i.rd(sdms_pkg::REG_AS_IND, d);
      chk(d, 32'hEDCB);
      sdms_far_i.rd(sdms_pkg::REG_STATUS, d);
      chk(d[12:11], 2'h3);
      sdms_far_i.vel_run(16'h00C8);
      repeat (4) @(posedge sys_clk_i);
      chk(drv, 1'b0);
   endtask
   // step mode in closed loop follows clock and direction pins
   task automatic t_step;
      sdms_far_i.restart(8'h09, 1'b1);
      sdms_far_i.pins(1'b1, 1'b1, 1'b1, 12'h0);
      repeat (8) @(posedge sys_clk_i);
      #1;
      chk({op_mode, step, sdir, cl, drv}, {sdms_pkg::OPM_CLKDIR, 4'hF});
      sdms_far_i.pins(1'b0, 1'b0, 1'b1, 12'h0);
      repeat (8) @(posedge sys_clk_i);
      #1;
      chk({step, drv}, 2'h0);
   endtask
   // switch moved while running is ignored until restart
   task automatic t_hold;
      sdms_far_i.restart(8'h14, 1'b1);
      sdms_far_i.set_sw(8'h3C, 1'b1);
      #1;
      chk({node_id, cl}, {8'h14, 1'b0});
      sdms_far_i.restart(8'h3C, 1'b1);
      #1;
      chk({node_id, cl}, {8'h3C, 1'b1});
   endtask
   // user scaling factor stretches the 100 rpm range
   task automatic t_scale;
      sdms_far_i.wr(sdms_pkg::REG_SCALE_NUM, 32'h3);
      sdms_far_i.wr(sdms_pkg::REG_SCALE_DEN, 32'h2);
      t_mode(8'h0D, 1'b0, 12'hFFF, 16'h0096);
   endtask
   // one switch code run with enable up, then enable dropped
   task automatic t_mode(input logic [7:0] s, input logic dr, input logic [11:0] a, input logic [15:0] v);
      sdms_far_i.restart(s, 1'b1);
      sdms_far_i.pins(1'b1, 1'b0, dr, a);
      repeat (10) @(posedge sys_clk_i);
      sdms_far_i.wr(sdms_pkg::REG_CTLWORD, 32'h6);
      repeat (4) @(posedge sys_clk_i);
      #1;
      chk({node_id, cl, drv, vel}, {s, s[3], 1'b1, v});
      if (s[2])
         chk(op_mode, sdms_pkg::OPM_VEL);
      sdms_far_i.pins(1'b0, 1'b0, dr, a);
      repeat (8) @(posedge sys_clk_i);
      #1;
      chk({drv, vel}, 17'h0);
   endtask
   // main sequence
   initial
   begin
      repeat (5) @(posedge sys_clk_i);
      srst_i <= 1'b0;
      repeat (6) @(posedge sys_clk_i);
      t_vel();
      t_auto();
      t_step();
      t_hold();
      t_mode(8'h02, 1'b0, 12'h000, 16'h001E);
      t_mode(8'h1B, 1'b0, 12'h000, 16'hFFE2);
      t_mode(8'h04, 1'b0, 12'hFFF, 16'h03E8);
      t_mode(8'h05, 1'b1, 12'hFFF, 16'hFF9C);
      t_mode(8'h0C, 1'b0, 12'h008, 16'h0000);
      t_mode(8'h06, 1'b0, 12'h000, 16'hFC18);
      t_mode(8'h0F, 1'b1, 12'h808, 16'h0000);
      t_mode(8'h0E, 1'b0, 12'hFFF, 16'h03E7);
      t_scale();
      results();
   end
   // hang guard, far beyond the expected run
   initial
   begin
      #200000;
      miscompares++;
      results();
   end
endmodule
